// [hdl/dac_link_if.sv]
`timescale 1ns/1ps
interface dac_link_if;
  logic sclk;
  logic cs_n;
  logic serial_data_in;

  modport host (
    output sclk,
    output cs_n,
    output serial_data_in
  );

  modport dev (
    input  sclk,
    input  cs_n,
    input  serial_data_in
  );
endinterface

// [hdl/dac_link_pkg.sv]
package dac_link_pkg;

  // Word layout, sent MSB first: lead address bit, three strap bits, then the code
  localparam int unsigned WORD_W      = 16;
  localparam int unsigned CODE_W      = 12;
  localparam int unsigned STRAP_W     = 3;
  localparam int unsigned ADDR_W      = 4;
  localparam int unsigned LEAD_POS    = 15;
  localparam int unsigned STRAP_HI    = 14;
  localparam int unsigned STRAP_LO    = 12;
  localparam int unsigned CODE_HI     = 11;
  localparam int unsigned CODE_LO     = 0;
  localparam logic        LEAD_VALUE  = 1'h0;
  localparam int unsigned COUNT_W     = 5;

  localparam logic [11:0] CODE_RESET  = 12'h000;

  // System clock rate and output settle limit after standby release
  localparam int unsigned CLK_MHZ     = 100;
  localparam int unsigned SETTLE_US   = 6;
  localparam int unsigned SETTLE_CYC  = SETTLE_US * CLK_MHZ;

  // Host serial clock: half period in system clock cycles
  localparam int unsigned HALF_CYC    = 4;
  localparam int unsigned DIV_W       = 8;

endpackage

// [hdl/dac_serial_host.sv]
`timescale 1ns/1ps
module dac_serial_host #(
  parameter int unsigned WORD_W   = dac_link_pkg::WORD_W,
  parameter int unsigned HALF_CYC = dac_link_pkg::HALF_CYC
) (
  input  wire logic              CLK_I,
  input  wire logic              SRST_I,
  input  wire logic              START_I,
  input  wire logic [WORD_W-1:0] WORD_I,
  output logic                   READY_O,
  output logic                   DONE_O,
  dac_link_if.host               link
);

  typedef enum logic [2:0] {
    H_IDLE  = 3'h0,
    H_SETUP = 3'h1,
    H_LOW   = 3'h3,
    H_HIGH  = 3'h2,
    H_HOLD  = 3'h6
  } host_fsm_t;

  typedef struct packed {
    host_fsm_t                      fsm;
    logic [WORD_W-1:0]              word;
    logic [dac_link_pkg::COUNT_W-1:0] bits;
    logic [dac_link_pkg::DIV_W-1:0]   div;
    logic                           sclk;
    logic                           cs_n;
    logic                           sdo;
    logic                           ready;
    logic                           done;
  } host_state_t;

  localparam int unsigned      DIV_W     = dac_link_pkg::DIV_W;
  localparam int unsigned      CNT_W     = dac_link_pkg::COUNT_W;
  localparam logic [DIV_W-1:0] DIV_LAST  = DIV_W'(HALF_CYC - 1);
  localparam logic [CNT_W-1:0] BITS_LAST = CNT_W'(WORD_W - 1);

  localparam host_state_t ST_RESET = '{
    fsm: H_IDLE, word: '0, bits: '0, div: '0,
    sclk: 1'b0, cs_n: 1'b1, sdo: 1'b0, ready: 1'b1, done: 1'b0
  };

  host_state_t st_reg;
  host_state_t st_next;

  always_comb begin
    st_next      = st_reg;
    st_next.done = 1'b0;
    if (st_reg.fsm != H_IDLE) begin
      st_next.div = st_reg.div + 1'b1;
    end
    case (st_reg.fsm)
      H_IDLE: begin
        // select low for the whole word
        if (START_I) begin
          st_next.fsm   = H_SETUP;
          st_next.word  = WORD_I;
          st_next.cs_n  = 1'b0;
          st_next.ready = 1'b0;
          st_next.bits  = '0;
          st_next.div   = '0;
          st_next.sdo   = WORD_I[WORD_W-1];
        end
      end
      H_SETUP: begin
        if (st_reg.div == DIV_LAST) begin
          st_next.fsm  = H_HIGH;
          st_next.sclk = 1'b1;
          st_next.div  = '0;
        end
      end
      H_HIGH: begin
        if (st_reg.div == DIV_LAST) begin
          st_next.sclk = 1'b0;
          st_next.div  = '0;
          // stop after exactly one full word
          if (st_reg.bits == BITS_LAST) begin
            st_next.fsm = H_HOLD;
          end else begin
            st_next.fsm  = H_LOW;
            st_next.bits = st_reg.bits + 1'b1;
            st_next.word = {st_reg.word[WORD_W-2:0], 1'b0};
            st_next.sdo  = st_reg.word[WORD_W-2];
          end
        end
      end
      H_LOW: begin
        if (st_reg.div == DIV_LAST) begin
          st_next.fsm  = H_HIGH;
          st_next.sclk = 1'b1;
          st_next.div  = '0;
        end
      end
      H_HOLD: begin
        if (st_reg.div == DIV_LAST) begin
          st_next.fsm   = H_IDLE;
          st_next.cs_n  = 1'b1;
          st_next.sdo   = 1'b0;
          st_next.ready = 1'b1;
          st_next.done  = 1'b1;
          st_next.div   = '0;
        end
      end
      default: begin
        st_next = ST_RESET;
      end
    endcase
  end

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      st_reg <= ST_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign link.sclk           = st_reg.sclk;
  assign link.cs_n           = st_reg.cs_n;
  assign link.serial_data_in = st_reg.sdo;
  assign READY_O             = st_reg.ready;
  assign DONE_O              = st_reg.done;

endmodule

// [hdl/dac_serial_loader.sv]
`timescale 1ns/1ps
// Summary of operation
// - Sample data on each rising serial clock
// - Select rising takes the shifted word
// - Extra bits push oldest out first
// - Upper four bits match, load twelve bits
// - Lead bit zero, then strap levels
// - Word MSB first, address then code
// - Standby low disables output stage
// - Code kept; output back within 6 us
// - Reset low clears code to zero
// - No loads during standby or reset
// - Host may share bus among eight
// - Paralleled devices share one address
// - Reset acts asynchronously, active low
// - Select low during shift, high completes
module dac_serial_loader #(
  parameter int unsigned WORD_W  = dac_link_pkg::WORD_W,
  parameter int unsigned CODE_W  = dac_link_pkg::CODE_W,
  parameter int unsigned STRAP_W = dac_link_pkg::STRAP_W
) (
  input  wire logic               CLK_I,
  input  wire logic               SRST_I,
  input  wire logic               RESET_N_I,
  input  wire logic               STANDBY_N_I,
  input  wire logic               ADDR_STRAP_HI_I,
  input  wire logic               ADDR_STRAP_MID_I,
  input  wire logic               ADDR_STRAP_LO_I,
  output logic [CODE_W-1:0]       CODE_O,
  output logic                    OUTPUT_EN_O,
  output logic                    LOADED_O,
  dac_link_if.dev                 link
);

  localparam int unsigned CNT_W = dac_link_pkg::COUNT_W;
  localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(WORD_W);

  // The lead bit must be zero, so an idle-high data line never matches an address
  function automatic logic addr_match(input logic [WORD_W-1:0]  word,
                                      input logic [STRAP_W-1:0] strap);
    logic lead_ok;
    logic strap_ok;
    lead_ok    = (word[dac_link_pkg::LEAD_POS] == dac_link_pkg::LEAD_VALUE);
    strap_ok   = (word[dac_link_pkg::STRAP_HI:dac_link_pkg::STRAP_LO] == strap);
    addr_match = lead_ok && strap_ok;
  endfunction

  // Link side: runs only on serial clock edges and on select falls

  typedef struct packed {
    logic [WORD_W-1:0] shift;
    logic [CNT_W-1:0]  count;
    logic              seen_id;
  } link_state_t;

  // Only the reset pin clears the link side; SRST_I stays on the system side
  localparam link_state_t LINK_RESET = '{
    shift:   '0,
    count:   '0,
    seen_id: 1'b0
  };

  logic        frame_id_reg;
  link_state_t lk_reg;
  link_state_t lk_next;

  // Marks each new frame; the bit counter restarts on the first edge of it
  always_ff @(negedge link.cs_n or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      frame_id_reg <= 1'b0;
    end else begin
      frame_id_reg <= ~frame_id_reg;
    end
  end

  always_comb begin
    lk_next = lk_reg;
    if (!link.cs_n) begin
      // oldest bit falls off the top
      lk_next.shift = {lk_reg.shift[WORD_W-2:0], link.serial_data_in};
      if (frame_id_reg != lk_reg.seen_id) begin
        lk_next.seen_id = frame_id_reg;
        lk_next.count   = CNT_W'(1);
      // Saturates at a full word so a long frame still qualifies
      end else if (lk_reg.count != CNT_FULL) begin
        lk_next.count = lk_reg.count + 1'b1;
      end
    end
  end

  // Shift register and counter live in the serial clock domain
  always_ff @(posedge link.sclk or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      lk_reg <= LINK_RESET;
    end else begin
      lk_reg <= lk_next;
    end
  end

  // System side

  typedef struct packed {
    logic               cs_meta;
    logic               cs_sync;
    logic               cs_prev;
    logic               rst_meta;
    logic               rst_sync;
    logic               sb_meta;
    logic               sb_sync;
    logic [STRAP_W-1:0] strap_meta;
    logic [STRAP_W-1:0] strap_sync;
    logic [CODE_W-1:0]  code;
    logic               out_en;
    logic               loaded;
  } sys_state_t;

  localparam sys_state_t SYS_RESET = '{
    cs_meta:    1'b1,
    cs_sync:    1'b1,
    cs_prev:    1'b1,
    rst_meta:   1'b0,
    rst_sync:   1'b0,
    sb_meta:    1'b0,
    sb_sync:    1'b0,
    strap_meta: '0,
    strap_sync: '0,
    code:       dac_link_pkg::CODE_RESET,
    out_en:     1'b0,
    loaded:     1'b0
  };

  sys_state_t st_reg;
  sys_state_t st_next;
  logic       frame_end;
  logic       frame_same;
  logic       word_full;
  logic       load_ok;
  logic       take_word;
  logic [1:0] rst_pipe_reg;
  logic       sys_rst_n;

  assign frame_end  = st_reg.cs_sync && !st_reg.cs_prev;
  // a frame with no serial clock must not reuse the last count
  assign frame_same = (lk_reg.seen_id == frame_id_reg);
  // Word and count are quiet here: select is high so the serial clock stands still
  assign word_full  = frame_same && (lk_reg.count == CNT_FULL);
  // gate loads by standby and reset
  assign load_ok    = st_reg.rst_sync && st_reg.sb_sync;
  // take the word at frame end
  assign take_word  = frame_end && word_full && load_ok;

  // Reset pin clears at once but is released two edges later,
  // so no flop sees the release close to a clock edge
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      rst_pipe_reg <= 2'h0;
    end else begin
      rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
    end
  end

  assign sys_rst_n = rst_pipe_reg[1];

  always_comb begin
    st_next            = st_reg;
    // Two-flop synchronisers; only the second stage is read
    st_next.cs_meta    = link.cs_n;
    st_next.cs_sync    = st_reg.cs_meta;
    st_next.cs_prev    = st_reg.cs_sync;
    st_next.rst_meta   = RESET_N_I;
    st_next.rst_sync   = st_reg.rst_meta;
    st_next.sb_meta    = STANDBY_N_I;
    st_next.sb_sync    = st_reg.sb_meta;
    // Straps are static; change them only while the link is idle
    st_next.strap_meta = {ADDR_STRAP_HI_I, ADDR_STRAP_MID_I, ADDR_STRAP_LO_I};
    st_next.strap_sync = st_reg.strap_meta;
    st_next.loaded     = 1'b0;
    // code held; output back well inside the settle limit
    st_next.out_en     = st_reg.sb_sync;
    if (take_word) begin
      if (addr_match(lk_reg.shift, st_reg.strap_sync)) begin
        st_next.code   = lk_reg.shift[dac_link_pkg::CODE_HI:dac_link_pkg::CODE_LO];
        st_next.loaded = 1'b1;
      end
    end
  end

  // reset pin clears the code without a clock
  // SRST_I is the system reset and clears the code on a rising CLK_I edge
  always_ff @(posedge CLK_I or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      st_reg <= SYS_RESET;
    end else if (SRST_I) begin
      st_reg <= SYS_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign CODE_O      = st_reg.code;
  assign OUTPUT_EN_O = st_reg.out_en;
  assign LOADED_O    = st_reg.loaded;

endmodule

// [tb/addressed_dac_serial_loader_tb.sv]
`timescale 1ns/1ps
module addressed_dac_serial_loader_tb;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        start = 1'b0;
  logic [15:0] word = 16'h0000;
  logic        rst_n = 1'b1;
  logic        sb_n = 1'b1;
  logic [2:0]  strap = 3'h5;
  logic        ready, done, oe, loaded;
  logic [11:0] code, code2, code3, code4;
  int          error_cnt = 0;
  int          total_checks = 0;
  int          cyc = 0;
  localparam realtime LINK_HALF = 7.5;
  dac_link_if lk ();
  dac_link_if lk2 ();
  always #5 clk = ~clk;
  dac_serial_host dac_serial_host_i (.CLK_I(clk), .SRST_I(srst), .START_I(start), .WORD_I(word),
    .READY_O(ready), .DONE_O(done), .link(lk.host));
  dac_serial_loader dac_serial_loader_i (.CLK_I(clk), .SRST_I(srst), .RESET_N_I(rst_n),
    .STANDBY_N_I(sb_n), .ADDR_STRAP_HI_I(strap[2]), .ADDR_STRAP_MID_I(strap[1]), .ADDR_STRAP_LO_I(strap[0]),
    .CODE_O(code), .OUTPUT_EN_O(oe), .LOADED_O(loaded), .link(lk.dev));
  // Second end on a bench-driven link, for frames the host never makes
  dac_serial_loader dac_serial_loader_i2 (.CLK_I(clk), .SRST_I(srst), .RESET_N_I(rst_n),
    .STANDBY_N_I(sb_n), .ADDR_STRAP_HI_I(strap[2]), .ADDR_STRAP_MID_I(strap[1]), .ADDR_STRAP_LO_I(strap[0]),
    .CODE_O(code2), .OUTPUT_EN_O(), .LOADED_O(), .link(lk2.dev));
  // Devices sharing the host's bus: one at another address, one paralleled at the same address
  dac_serial_loader dac_serial_loader_i3 (.CLK_I(clk), .SRST_I(srst), .RESET_N_I(rst_n),
    .STANDBY_N_I(sb_n), .ADDR_STRAP_HI_I(1'b0), .ADDR_STRAP_MID_I(1'b1), .ADDR_STRAP_LO_I(1'b0),
    .CODE_O(code3), .OUTPUT_EN_O(), .LOADED_O(), .link(lk.dev));
  dac_serial_loader dac_serial_loader_i4 (.CLK_I(clk), .SRST_I(srst), .RESET_N_I(rst_n),
    .STANDBY_N_I(sb_n), .ADDR_STRAP_HI_I(strap[2]), .ADDR_STRAP_MID_I(strap[1]), .ADDR_STRAP_LO_I(strap[0]),
    .CODE_O(code4), .OUTPUT_EN_O(), .LOADED_O(), .link(lk.dev));
  dac_link_asserts dac_link_asserts_i (.CLK_I(clk), .SRST_I(srst), .sclk(lk.sclk), .cs_n(lk.cs_n),
    .serial_data_in(lk.serial_data_in), .CODE_O(code), .LOADED_O(loaded), .OUTPUT_EN_O(oe),
    .STANDBY_N_I(sb_n), .RESET_N_I(rst_n));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic send(input logic [15:0] w);
    int n;
    n = 0;
    @(negedge clk);
    start = 1'b1;
    word = w;
    @(negedge clk);
    start = 1'b0;
    chk({14'h0, ready, lk.cs_n}, 16'h0000);
    while (done !== 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    chk({15'h0, done}, 16'h0001);
    chk({15'h0, ready}, 16'h0001);
    repeat (8) @(negedge clk);
  endtask
  task automatic bang(input logic [19:0] w, input int n);
    @(negedge clk);
    #2;
    lk2.cs_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      lk2.serial_data_in = w[i];
      #(LINK_HALF);
      lk2.sclk = 1'b1;
      #(LINK_HALF);
      lk2.sclk = 1'b0;
    end
    // Stale data would hide a late sample, so the released line flips
    lk2.serial_data_in = ~w[0];
    #(LINK_HALF);
    lk2.cs_n = 1'b1;
    repeat (8) @(negedge clk);
  endtask
  task automatic t_load();
    send(16'h5ABC);
    chk({4'h0, code}, 16'h0ABC);
    send(16'h5123);
    chk({4'h0, code}, 16'h0123);
    send(16'hD777);
    chk({4'h0, code}, 16'h0123);
    send(16'h4777);
    chk({4'h0, code}, 16'h0123);
    chk({4'h0, code4}, 16'h0123);
    chk({4'h0, code3}, 16'h0000);
    send(16'h2ABC);
    chk({4'h0, code3}, 16'h0ABC);
    chk({4'h0, code}, 16'h0123);
    $display("test load done");
  endtask
  task automatic t_stby();
    sb_n = 1'b0;
    repeat (5) @(negedge clk);
    chk({15'h0, oe}, 16'h0000);
    send(16'h5456);
    chk({4'h0, code}, 16'h0123);
    sb_n = 1'b1;
    repeat (5) @(negedge clk);
    chk({3'h0, oe, code}, 16'h1123);
    $display("test standby done");
  endtask
  task automatic t_rst();
    rst_n = 1'b0;
    #1;
    chk({4'h0, code}, 16'h0000);
    send(16'h5789);
    chk({4'h0, code}, 16'h0000);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    send(16'h5789);
    chk({4'h0, code}, 16'h0789);
    $display("test reset done");
  endtask
  task automatic t_bits();
    bang(20'hF5320, 20);
    chk({4'h0, code2}, 16'h0320);
    bang(20'h05FFF, 15);
    chk({4'h0, code2}, 16'h0320);
    $display("test bit count done");
  endtask
  task automatic give_verdict();
    $display("checks=%0d mismatches=%0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    lk2.cs_n = 1'b1;
    lk2.sclk = 1'b0;
    lk2.serial_data_in = 1'b0;
    repeat (16) @(negedge clk);
    srst = 1'b0;
    repeat (4) @(negedge clk);
    t_load();
    t_stby();
    t_rst();
    t_bits();
    give_verdict();
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      give_verdict();
    end
  end
endmodule

// [tb/dac_link_asserts.sv]
`timescale 1ns/1ps
module dac_link_asserts (
  input wire logic        CLK_I,
  input wire logic        SRST_I,
  input wire logic        sclk,
  input wire logic        cs_n,
  input wire logic        serial_data_in,
  input wire logic [11:0] CODE_O,
  input wire logic        LOADED_O,
  input wire logic        OUTPUT_EN_O,
  input wire logic        STANDBY_N_I,
  input wire logic        RESET_N_I
);
  localparam int SETTLE_LIM = dac_link_pkg::SETTLE_CYC;
  logic [15:0] shw_reg;
  logic [4:0]  cnt_reg;
  default clocking @(posedge CLK_I); endclocking
  default disable iff (SRST_I);
  // Mirror of the wire; host edges are registered, so sampling on CLK_I is exact
  always_ff @(posedge CLK_I) begin
    if (SRST_I || $fell(cs_n)) begin
      cnt_reg <= 5'h00;
    end else if ($rose(sclk) && !cs_n && cnt_reg != 5'h10) begin
      cnt_reg <= cnt_reg + 5'h01;
    end
    if ($rose(sclk) && !cs_n) begin
      shw_reg <= {shw_reg[14:0], serial_data_in};
    end
  end
  AST_SCLK_IDLE: assert property (cs_n |-> !sclk)
    else $error("serial clock moved while deselected");
  AST_LOAD_WORD: assert property (LOADED_O |-> cs_n && CODE_O == shw_reg[11:0] && !shw_reg[15]
    && cnt_reg == 5'h10) else $error("loaded code differs from word on wire");
  AST_LOAD_PULSE: assert property (LOADED_O |=> !LOADED_O)
    else $error("load pulse too long");
  AST_CODE_HOLD: assert property (!LOADED_O && RESET_N_I && $past(RESET_N_I) |-> $stable(CODE_O))
    else $error("code changed without a load");
  AST_RESET_ZERO: assert property (!RESET_N_I |-> CODE_O == 12'h000)
    else $error("code not cleared in reset");
  AST_RESET_NOLOAD: assert property (!RESET_N_I |-> !LOADED_O)
    else $error("load during reset");
  AST_STBY_NOLOAD: assert property ((!STANDBY_N_I)[*5] |-> !LOADED_O)
    else $error("load during standby");
  AST_STBY_OFF: assert property ($fell(STANDBY_N_I) |-> ##[1:4] !OUTPUT_EN_O)
    else $error("output stage not disabled");
  AST_STBY_BACK: assert property ($rose(STANDBY_N_I) |-> ##[1:SETTLE_LIM] OUTPUT_EN_O)
    else $error("output stage not restored");
  cover property (LOADED_O);
  cover property ($rose(STANDBY_N_I));
  cover property ($fell(RESET_N_I));
endmodule
